// ==== gpio_cfg.svh ====
// Behaviour
// - The block serves 22 pins: port 0 bits 0 to 5, port 1 bits 0 to 7 and port 5 bits 0 to 7.
// - A direction bit of 0 makes its pin an input and 1 an output, and every direction bit resets to 0.
// - Single direction bits can be set or cleared without disturbing the other bits of the register.
// - Port 0 pin 5 is input only and its direction position always reads as 1.
// - Port 0 pin 5 has no pull-up and its pull-up position is held at 0.
// - With the reset-pin option on, the port 0 bit 5 data value reads as a constant 1.
// - With the reset-pin option on, port 0 pin 5 acts as the reset input and not as an I/O pin.
// - With the comparator on, the channel field connects one pin to its negative input: 0 to 7 port 1, 8 to 11 port 5.
`ifndef GPIO_CFG_SVH
`define GPIO_CFG_SVH
`define ADDR_P0_DIR   8'hB8
`define ADDR_P1_DIR   8'hC1
`define ADDR_P5_DIR   8'hC5
`define ADDR_P0_DATA  8'hD0
`define ADDR_P1_DATA  8'hD1
`define ADDR_P5_DATA  8'hD5
`define ADDR_P0_PU    8'hE0
`define ADDR_P1_PU    8'hE1
`define ADDR_P5_PU    8'hE5
`define RST_REG       8'h00
`define P0_RESET_BIT  5
`define P0_MASK       8'h3F
`define CMP_CH_P5_LO  4'h8
`define CMP_CH_LAST   4'hB
`endif

// ==== gpio_pkg.sv ====
package gpio_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    BIT_NONE = 2'b00,
    BIT_SET  = 2'b01,
    BIT_CLR  = 2'b10
  } bit_op_e;
endpackage

// ==== gpio_port_bank.sv ====
`timescale 1ns/1ps
`include "gpio_cfg.svh"
// One 8-bit port: direction, pull-up and output latch with bit set and clear.
module gpio_port_bank
  import gpio_pkg::*;
(
  input  wire logic  clk,         // System clock.
  input  wire logic  rst_n,       // Synchronous reset, active low.
  input  wire logic  dir_wr,      // Whole-byte write of direction.
  input  wire logic  data_wr,     // Whole-byte write of the output latch.
  input  wire logic  pu_wr,       // Whole-byte write of pull-up enables.
  input  wire logic  dir_bit_en,  // Single-bit operation on direction.
  input  wire logic  data_bit_en, // Single-bit operation on the latch.
  input  bit_op_e    bit_op,      // Set or clear for single-bit access.
  input  wire [2:0]  bit_sel,     // Bit index for single-bit access.
  input  byte_t      wdata,       // Write data.
  output byte_t      direction,   // Direction register.
  output byte_t      out_latch,   // Output latch.
  output byte_t      pu_en        // Pull-up enable register.
);

  // Applies a single-bit set or clear to one byte.
  function automatic byte_t bit_apply(input byte_t cur, input bit_op_e op, input logic [2:0] sel);
    byte_t r;
    r = cur;
    if (op == BIT_SET) begin
      r[sel] = 1'b1;
    end else if (op == BIT_CLR) begin
      r[sel] = 1'b0;
    end
    return r;
  endfunction

  // Direction register; reset leaves every pin an input.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      direction <= `RST_REG;
    end else if (dir_wr) begin
      direction <= wdata;
    end else if (dir_bit_en) begin
      direction <= bit_apply(direction, bit_op, bit_sel);
    end
  end

  // Output latch, loaded by byte or single-bit writes.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_latch <= `RST_REG;
    end else if (data_wr) begin
      out_latch <= wdata;
    end else if (data_bit_en) begin
      out_latch <= bit_apply(out_latch, bit_op, bit_sel);
    end
  end

  // Pull-up enables, write only from software.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pu_en <= `RST_REG;
    end else if (pu_wr) begin
      pu_en <= wdata;
    end
  end

endmodule

// ==== gpio_block.sv ====
`timescale 1ns/1ps
`include "gpio_cfg.svh"
// Three-port GPIO block with shared-function pin takeover.
module gpio_block
  import gpio_pkg::*;
(
  input  wire logic        clk,                          // System clock, 40 MHz.
  input  wire logic        rst_n,                        // Synchronous reset, active low.
  input  wire logic [7:0]  addr,                         // Register address.
  input  wire logic        wr_en,                        // Byte write strobe.
  input  wire logic        rd_en,                        // Read strobe.
  input  bit_op_e          bit_op,                       // Single-bit set or clear.
  input  wire logic [2:0]  bit_sel,                      // Bit index for bit operations.
  input  byte_t            wdata,                        // Write data.
  output byte_t            rdata,                        // Read data, registered.
  input  wire logic        reset_pin_option,             // Configuration: pin 0.5 is reset.
  input  wire logic [21:0] pin_in,                       // Pin levels: [5:0] port0, [13:6] port1, [21:14] port5.
  output logic      [21:0] pin_out,                      // Pin drive levels.
  output logic      [21:0] pin_oe,                       // High while the pin is driven.
  output logic      [21:0] pin_pullup,                   // Pull-up on per pin.
  output logic             ext_reset_n,                  // Reset request from pin 0.5, active low.
  input  wire logic        ext_irq_pin_enable,           // External interrupt uses pin 0.0.
  output logic             external_irq_input,           // Pin 0.0 level to the interrupt logic.
  input  wire logic        comparator_enable,            // Comparator on.
  input  wire logic        comparator_output_pin_enable, // Comparator output to pin 0.0.
  input  wire logic        comparator_output,            // Comparator result.
  input  wire logic [3:0]  comparator_channel_select,    // Negative input channel.
  output logic      [21:0] comparator_neg_input_ch,      // One-hot analog switch per pin.
  input  wire logic        timer_a_enable,               // Timer A running.
  input  wire logic [7:0]  lowpower_wave_out_select,     // Waveform output enables.
  input  wire logic [7:0]  lowpower_wave_output,         // Waveform levels.
  input  wire logic        timer_b_enable,               // Timer B running.
  input  wire logic        pwm_pin_output_enable,        // PWM to pin 5.3.
  input  wire logic        pwm_output,                   // PWM level.
  input  wire logic        serial_port_enable,           // Serial port on pins 5.0 to 5.2.
  input  wire logic        serial_clk_out,               // Serial clock level.
  input  wire logic        serial_clk_oe,                // Serial clock driven.
  input  wire logic        serial_data_out,              // Serial data output level.
  input  wire logic        two_wire_port_enable,         // Two-wire port on pins 5.0 and 5.1.
  input  wire logic        two_wire_scl_oe,              // Two-wire clock pulled low.
  input  wire logic        two_wire_sda_oe,              // Two-wire data pulled low.
  output logic             serial_clk_in,                // Pin 5.0 level to serial logic.
  output logic             serial_data_in                // Pin 5.1 level to serial logic.
);

  byte_t dir0, dir1, dir5;
  byte_t lat0, lat1, lat5;
  byte_t pu0, pu1, pu5;
  logic [21:0] dir_all, lat_all, pu_all;
  logic [21:0] fn_take, fn_level, fn_oe;
  logic        bit_access;
  byte_t       next_rdata;

  // Address decode; a single-bit operation is marked by a non-idle bit_op.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr);
    return a == ref_addr;
  endfunction

  assign bit_access = (bit_op != BIT_NONE);

  // The three ports share one bank structure.
  gpio_port_bank u_port0 (
    .clk         (clk),
    .rst_n       (rst_n),
    .dir_wr      (wr_en && !bit_access && hit(addr, `ADDR_P0_DIR)),
    .data_wr     (wr_en && !bit_access && hit(addr, `ADDR_P0_DATA)),
    .pu_wr       (wr_en && !bit_access && hit(addr, `ADDR_P0_PU)),
    .dir_bit_en  (wr_en && bit_access && hit(addr, `ADDR_P0_DIR)),
    .data_bit_en (wr_en && bit_access && hit(addr, `ADDR_P0_DATA)),
    .bit_op      (bit_op),
    .bit_sel     (bit_sel),
    .wdata       (wdata),
    .direction   (dir0),
    .out_latch   (lat0),
    .pu_en       (pu0)
  );
  gpio_port_bank u_port1 (
    .clk         (clk),
    .rst_n       (rst_n),
    .dir_wr      (wr_en && !bit_access && hit(addr, `ADDR_P1_DIR)),
    .data_wr     (wr_en && !bit_access && hit(addr, `ADDR_P1_DATA)),
    .pu_wr       (wr_en && !bit_access && hit(addr, `ADDR_P1_PU)),
    .dir_bit_en  (wr_en && bit_access && hit(addr, `ADDR_P1_DIR)),
    .data_bit_en (wr_en && bit_access && hit(addr, `ADDR_P1_DATA)),
    .bit_op      (bit_op),
    .bit_sel     (bit_sel),
    .wdata       (wdata),
    .direction   (dir1),
    .out_latch   (lat1),
    .pu_en       (pu1)
  );
  gpio_port_bank u_port5 (
    .clk         (clk),
    .rst_n       (rst_n),
    .dir_wr      (wr_en && !bit_access && hit(addr, `ADDR_P5_DIR)),
    .data_wr     (wr_en && !bit_access && hit(addr, `ADDR_P5_DATA)),
    .pu_wr       (wr_en && !bit_access && hit(addr, `ADDR_P5_PU)),
    .dir_bit_en  (wr_en && bit_access && hit(addr, `ADDR_P5_DIR)),
    .data_bit_en (wr_en && bit_access && hit(addr, `ADDR_P5_DATA)),
    .bit_op      (bit_op),
    .bit_sel     (bit_sel),
    .wdata       (wdata),
    .direction   (dir5),
    .out_latch   (lat5),
    .pu_en       (pu5)
  );

  // Flat 22-pin views; pin 0.5 is never an output and has no pull-up.
  assign dir_all = {dir5, dir1, 1'b0, dir0[4:0]};
  assign lat_all = {lat5, lat1, 1'b0, lat0[4:0]};
  assign pu_all  = {pu5, pu1, 1'b0, pu0[4:0]};

  // Shared digital functions claim their pins while enabled.
  always_comb begin
    fn_take  = '0;
    fn_level = '0;
    fn_oe    = '0;
    if (ext_irq_pin_enable) begin
      fn_take[0] = 1'b1;
    end
    if (comparator_enable && comparator_output_pin_enable) begin
      fn_take[0]  = 1'b1;
      fn_level[0] = comparator_output;
      fn_oe[0]    = 1'b1;
    end
    if (timer_a_enable) begin
      for (int i = 0; i < 4; i++) begin
        if (lowpower_wave_out_select[i]) begin
          fn_take[1 + i]  = 1'b1;
          fn_level[1 + i] = lowpower_wave_output[i];
          fn_oe[1 + i]    = 1'b1;
        end
      end
      for (int i = 4; i < 8; i++) begin
        if (lowpower_wave_out_select[i]) begin
          fn_take[14 + i]  = 1'b1;
          fn_level[14 + i] = lowpower_wave_output[i];
          fn_oe[14 + i]    = 1'b1;
        end
      end
    end
    if (timer_b_enable && pwm_pin_output_enable) begin
      fn_take[17]  = 1'b1;
      fn_level[17] = pwm_output;
      fn_oe[17]    = 1'b1;
    end
    if (serial_port_enable) begin
      fn_take[16:14]  = 3'b111;
      fn_level[14]    = serial_clk_out;
      fn_oe[14]       = serial_clk_oe;
      fn_level[16]    = serial_data_out;
      fn_oe[16]       = 1'b1;
    end else if (two_wire_port_enable) begin
      fn_take[15:14] = 2'b11;
      fn_oe[14]      = two_wire_scl_oe;
      fn_oe[15]      = two_wire_sda_oe;
    end
  end

  // Comparator negative input switch, one pin at a time.
  always_comb begin
    comparator_neg_input_ch = '0;
    if (comparator_enable) begin
      if (comparator_channel_select < `CMP_CH_P5_LO) begin
        comparator_neg_input_ch[6 + comparator_channel_select[2:0]] = 1'b1;
      end else if (comparator_channel_select <= `CMP_CH_LAST) begin
        comparator_neg_input_ch[18 + comparator_channel_select[1:0]] = 1'b1;
      end
    end
  end

  // Pin drive: shared function first, else the latch on output pins.
  // A selected comparator channel is analog, so its latch driver is off; a shared function that claims the pin still drives it.
  always_comb begin
    for (int i = 0; i < 22; i++) begin
      if (fn_take[i]) begin
        pin_out[i] = fn_level[i];
        pin_oe[i]  = fn_oe[i];
      end else begin
        pin_out[i] = lat_all[i];
        pin_oe[i]  = dir_all[i] && !comparator_neg_input_ch[i];
      end
    end
    pin_pullup = pu_all;
  end

  // Pin 0.5 feeds the reset logic when so configured, else it is an input.
  assign ext_reset_n        = reset_pin_option ? pin_in[`P0_RESET_BIT] : 1'b1;
  assign external_irq_input = ext_irq_pin_enable ? pin_in[0] : 1'b0;
  assign serial_clk_in      = pin_in[14];
  assign serial_data_in     = pin_in[15];

  // Read mux: inputs return pin levels, outputs the latch; pull-ups read zero.
  always_comb begin
    next_rdata = `RST_REG;
    case (addr)
      `ADDR_P0_DIR: begin
        next_rdata = {2'b00, 1'b1, dir0[4:0]};
      end
      `ADDR_P1_DIR: begin
        next_rdata = dir1;
      end
      `ADDR_P5_DIR: begin
        next_rdata = dir5;
      end
      `ADDR_P0_DATA: begin
        next_rdata = {2'b00, (reset_pin_option ? 1'b1 : pin_in[`P0_RESET_BIT]),
                      (dir0[4:0] & lat0[4:0]) | (~dir0[4:0] & pin_in[4:0])};
      end
      `ADDR_P1_DATA: begin
        next_rdata = (dir1 & lat1) | (~dir1 & pin_in[13:6]);
      end
      `ADDR_P5_DATA: begin
        next_rdata = (dir5 & lat5) | (~dir5 & pin_in[21:14]);
      end
      default: begin
        next_rdata = `RST_REG;
      end
    endcase
  end

  // Registered read data, held between reads.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= `RST_REG;
    end else if (rd_en) begin
      rdata <= next_rdata;
    end
  end

endmodule

// ==== gpio_block_chk.sv ====
`timescale 1ns/1ps
`include "gpio_cfg.svh"
// Checks register read-back and pin behaviour of the GPIO block at its ports.
module gpio_block_chk
  import gpio_pkg::*;
(
  input wire logic        clk,                       // Clock.
  input wire logic        rst_n,                     // Reset, active low.
  input wire logic [7:0]  addr,                      // Address.
  input wire logic        wr_en,                     // Write strobe.
  input wire logic        rd_en,                     // Read strobe.
  input bit_op_e          bit_op,                    // Bit operation.
  input wire logic [2:0]  bit_sel,                   // Bit index.
  input byte_t            wdata,                     // Write data.
  input byte_t            rdata,                     // Read data.
  input wire logic        reset_pin_option,          // Reset-pin option.
  input wire logic [21:0] pin_in,                    // Pin levels.
  input wire logic [21:0] pin_oe,                    // Pin enables.
  input wire logic [21:0] pin_pullup,                // Pull-ups.
  input wire logic        ext_reset_n,               // Reset request.
  input wire logic        comparator_enable,         // Comparator on.
  input wire logic [3:0]  comparator_channel_select, // Channel.
  input wire logic [21:0] comparator_neg_input_ch    // Analog switches.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Each property but p_pin5 ties an output to the request or input that causes it; p_pin5 holds pin 0.5 undriven and without pull-up.
  property p_dir5; rd_en && addr == `ADDR_P0_DIR |=> rdata[5]; endproperty
  a_dir5: assert property (p_dir5) else $error("port0 direction bit 5 read 0");
  property p_dat5; reset_pin_option && rd_en && addr == `ADDR_P0_DATA |=> rdata[5]; endproperty
  a_dat5: assert property (p_dat5) else $error("port0 data bit 5 read 0");
  property p_rst; ext_reset_n == (reset_pin_option ? pin_in[5] : 1'b1); endproperty
  a_rst: assert property (p_rst) else $error("reset request wrong");
  property p_pin5; !pin_oe[5] && !pin_pullup[5]; endproperty
  a_pin5: assert property (p_pin5) else $error("pin 0.5 driven or pulled up");
  property p_cmp;
    comparator_enable && comparator_channel_select <= `CMP_CH_LAST |-> comparator_neg_input_ch ==
      22'h1 << (comparator_channel_select + (comparator_channel_select < `CMP_CH_P5_LO ? 5'd6 : 5'd10));
  endproperty
  a_cmp: assert property (p_cmp) else $error("comparator channel switch wrong");
  property p_dirwr;
    wr_en && bit_op == BIT_NONE && addr == `ADDR_P1_DIR ##1 !comparator_enable |-> pin_oe[13:6] == $past(wdata);
  endproperty
  a_dirwr: assert property (p_dirwr) else $error("port1 direction write not at pins");
  property p_bset;
    !comparator_enable && wr_en && bit_op == BIT_SET && addr == `ADDR_P1_DIR ##1 !comparator_enable
      |-> pin_oe[13:6] == ($past(pin_oe[13:6]) | 8'h01 << $past(bit_sel));
  endproperty
  a_bset: assert property (p_bset) else $error("bit set disturbed other bits");
  property p_rdin;
    !comparator_enable && rd_en && addr == `ADDR_P1_DATA |=>
      ((rdata ^ $past(pin_in[13:6])) & ~$past(pin_oe[13:6])) == 8'h00;
  endproperty
  a_rdin: assert property (p_rdin) else $error("input pin level not read back");

  // Main scenarios that should be reached.
  c_cmp: cover property (comparator_enable && comparator_channel_select == `CMP_CH_LAST);
  c_opt: cover property (reset_pin_option && rd_en && addr == `ADDR_P0_DATA);
  c_bit: cover property (wr_en && bit_op == BIT_SET);
endmodule

bind gpio_block gpio_block_chk i_gpio_block_chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_en(wr_en),
  .rd_en(rd_en), .bit_op(bit_op), .bit_sel(bit_sel), .wdata(wdata), .rdata(rdata),
  .reset_pin_option(reset_pin_option), .pin_in(pin_in), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
  .ext_reset_n(ext_reset_n), .comparator_enable(comparator_enable),
  .comparator_channel_select(comparator_channel_select), .comparator_neg_input_ch(comparator_neg_input_ch));

// ==== gpio_pins_model.sv ====
`timescale 1ns/1ps
// Board side of the pins: block driver, outside source, pull-up or a floating line.
module gpio_pins_model (
  input  wire logic        clk,        // System clock.
  input  wire logic [21:0] pin_out,    // Block drive levels.
  input  wire logic [21:0] pin_oe,     // Block drive enables.
  input  wire logic [21:0] pin_pullup, // Pull-ups on.
  input  wire logic [21:0] ext_val,    // Outside source levels.
  input  wire logic [21:0] ext_en,     // Outside source active.
  output logic      [21:0] pin_in      // Resolved pin levels.
);
  logic [21:0] float_pat = 22'h0;
  // A floating line changes every cycle so that no stale level reads back.
  always @(posedge clk) float_pat <= ~float_pat;
  // Block driver wins, then the outside source, then the pull-up, else the line floats.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | (~ext_en & (pin_pullup | float_pat))));
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
`include "gpio_cfg.svh"
// Self-checking bench for the three-port GPIO block.
module testbench import gpio_pkg::*;;
  typedef struct packed { logic [7:0] a; logic [7:0] w; logic [7:0] r; } row_s;
  logic        clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, opt = 1'b0;
  logic [7:0]  addr = 8'h00, fn_on = 8'h00, lpw_sel = 8'h00, lpw_out = 8'h00;
  bit_op_e     bit_op = BIT_NONE;
  logic [2:0]  bit_sel = 3'h0;
  byte_t       wdata = 8'h00, rdata;
  logic [3:0]  cmp_sel = 4'h0;
  logic [21:0] pin_in, pin_out, pin_oe, pin_pu, cmp_ch, ext_val = 22'h155555, ext_en = 22'h3FFFFF;
  logic        ext_reset_n, irq_in, pwm_out = 1'b0, sck = 1'b0, sck_oe = 1'b0, sdo = 1'b0, tw_en = 1'b0;
  logic        sck_in, sdi;
  int          errors = 0, n_tests = 0;
  row_s        rows [8] = '{'{8'hC1, 8'hFF, 8'hFF}, '{8'hC5, 8'h0F, 8'h0F}, '{8'hB8, 8'hFF, 8'h3F},
    '{8'hD1, 8'hA5, 8'hA5}, '{8'hD5, 8'h3C, 8'h5C}, '{8'hD0, 8'h0A, 8'h0A}, '{8'hE1, 8'hFF, 8'h00},
    '{8'h80, 8'hFF, 8'h00}};

  // Clock at 40 MHz.
  always #12.5 clk = ~clk;

  gpio_block i_gpio_block (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .bit_op(bit_op), .bit_sel(bit_sel), .wdata(wdata), .rdata(rdata), .reset_pin_option(opt),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pu), .ext_reset_n(ext_reset_n),
    .ext_irq_pin_enable(fn_on[7]), .external_irq_input(irq_in), .comparator_enable(fn_on[0]),
    .comparator_output_pin_enable(fn_on[1]), .comparator_output(fn_on[2]), .comparator_channel_select(cmp_sel),
    .comparator_neg_input_ch(cmp_ch), .timer_a_enable(fn_on[3]), .lowpower_wave_out_select(lpw_sel),
    .lowpower_wave_output(lpw_out), .timer_b_enable(fn_on[4]), .pwm_pin_output_enable(fn_on[5]),
    .pwm_output(pwm_out), .serial_port_enable(fn_on[6]), .serial_clk_out(sck), .serial_clk_oe(sck_oe),
    .serial_data_out(sdo), .two_wire_port_enable(tw_en), .two_wire_scl_oe(sck_oe), .two_wire_sda_oe(sck_oe),
    .serial_clk_in(sck_in), .serial_data_in(sdi));
  gpio_pins_model i_gpio_pins_model (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pu),
    .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  // Counts a comparison and reports a mismatch.
  task automatic chk(input string name, input logic [21:0] exp, input logic [21:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One register write, taken at the edge after the strobe rises.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit_op_e op = BIT_NONE,
                    input logic [2:0] s = 3'h0);
    @(posedge clk);
    addr    <= a;
    wdata   <= d;
    bit_op  <= op;
    bit_sel <= s;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
    bit_op  <= BIT_NONE;
  endtask

  // One register read, compared once the registered data has landed.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk("rdata", {14'h0, e}, {14'h0, rdata});
  endtask

  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    wrap_up();
  end

  // Main sequence: reset values, table rows, then the awkward cases.
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(`ADDR_P0_DIR, 8'h20);
    rd(`ADDR_P5_DIR, 8'h00);
    rd(`ADDR_P1_DATA, 8'h55);
    chk("pin_oe", 22'h0, pin_oe);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].r);
    end
    chk("pin_oe", 22'h3FFDF, pin_oe);
    chk("pin_out", 22'h2940, pin_out & 22'h3FC0);
    wr(`ADDR_P1_DIR, 8'h00, BIT_CLR, 3'h3);
    rd(`ADDR_P1_DIR, 8'hF7);
    wr(`ADDR_P1_DIR, 8'h00, BIT_SET, 3'h3);
    wr(`ADDR_P1_DIR, 8'h00, BIT_CLR, 3'h7);
    rd(`ADDR_P1_DIR, 8'h7F);
    wr(`ADDR_P1_DATA, 8'h00, BIT_SET, 3'h1);
    rd(`ADDR_P1_DATA, 8'h27);
    wr(`ADDR_P0_PU, 8'hFF);
    #1 chk("pin_pullup", 22'h3FDF, pin_pu & 22'h3FFF);
    @(posedge clk);
    opt    <= 1'b1;
    ext_en <= 22'h3FDFFF;
    rd(`ADDR_P0_DATA, 8'h2A);
    rd(`ADDR_P1_DATA, 8'hA7);
    chk("ext_reset_n", 22'h0, {21'h0, ext_reset_n});
    for (int c = 0; c < 12; c++) begin
      @(posedge clk);
      fn_on   <= 8'h01;
      cmp_sel <= 4'(c);
      #1 chk("cmp_ch", 22'h1 << (c < 8 ? c + 6 : c + 10), cmp_ch);
    end
    @(posedge clk);
    fn_on   <= 8'hFF;
    lpw_sel <= 8'h01;
    #1 chk("pin_out", 22'h1, pin_out & 22'h30003);
    chk("irq_in", 22'h1, {21'h0, irq_in});
    @(posedge clk);
    fn_on   <= 8'h00;
    #1 chk("pin_out", 22'h30002, pin_out & 22'h30003);
    @(posedge clk);
    tw_en <= 1'b1;
    #1 chk("pin_oe", 22'h30000, pin_oe & 22'h3C000);
    chk("serial_in", 22'h2, {20'h0, sck_in, sdi});
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(`ADDR_P1_DIR, 8'h00);
    chk("pin_oe", 22'h0, pin_oe);
    wrap_up();
  end
endmodule
